/* File: inc/sssr_pkg.sv */
// constants and carrier types for the serial shift and storage register block
// ==========================================================================
// Overview of operation
// R1 - each shift clock rise moves the eight stages on and loads the data bit
// R2 - each storage clock rise copies all eight stages into the storage register
// R3 - shift and storage clocks are independent inputs, both acting on rising edges
// R4 - a low shift clear zeroes every stage at once, overriding shifting
// R5 - the last stage is driven on the cascade output for chaining devices
// R6 - with both clocks tied, storage holds the stages from one pulse earlier
// R7 - parallel outputs come from the storage register, changing only on storage clock
// R8 - output enable high floats the parallel outputs, low drives the stored value
package sssr_pkg;

	// ======================================================================
	// sizes
	localparam int SSSR_STAGES = 8;
	localparam int SSSR_FIFO_DEPTH = 8;
	localparam int SSSR_SYNC_DEPTH = 2;

	// ======================================================================
	// timing: least time from one pop to the next on the drain side
	localparam int SSSR_CLK_PERIOD_PS = 4000;
	localparam int SSSR_DRAIN_GAP_PS = 4000;
	localparam int SSSR_DRAIN_GAP_CYC =
		(SSSR_DRAIN_GAP_PS + SSSR_CLK_PERIOD_PS - 1) / SSSR_CLK_PERIOD_PS;

	// ======================================================================
	// reset values
	localparam logic [SSSR_STAGES-1:0] SSSR_STAGES_RST = 8'h00;
	localparam logic [SSSR_STAGES-1:0] SSSR_STAGES_CLR = 8'h00;
	localparam logic SSSR_LEVEL_LOW = 1'h0;
	localparam logic SSSR_LEVEL_HIGH = 1'h1;

	// ======================================================================
	// pin group as sampled from outside the clock domain
	typedef struct packed {
		logic bit_input;
		logic shift_clk;
		logic store_clk;
		logic shift_clear_n;
		logic out_en_n;
	} sssr_pins_t;

	// one queued clock event: shift and store may come together
	typedef struct packed {
		logic do_shift;
		logic do_store;
		logic bit_val;
	} sssr_evt_t;

	localparam sssr_pins_t SSSR_PINS_RST = '{
		bit_input: 1'h0,
		shift_clk: 1'h0,
		store_clk: 1'h0,
		shift_clear_n: 1'h1,
		out_en_n: 1'h1
	};

endpackage

/* File: logic/sssr_sync.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module sssr_sync
	import sssr_pkg::*;
#(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// first stage is read only by the second stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;

endmodule

/* File: logic/sssr_fifo.sv */
// small flip-flop fifo with valid/ready on both sides and a flush
`timescale 1ns/100ps
module sssr_fifo
	import sssr_pkg::*;
#(
	parameter int WIDTH = 3,
	parameter int DEPTH = SSSR_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage, written at the write index
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	// pointers and fill level; flush empties the queue
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

/* File: logic/sssr_core.sv */
// serial-in parallel-out shift register with storage register, pin sampled
`timescale 1ns/100ps
module sssr_core
	import sssr_pkg::*;
#(
	parameter int STAGES = SSSR_STAGES,
	parameter int DEPTH = SSSR_FIFO_DEPTH,
	parameter int DRAIN_GAP = SSSR_DRAIN_GAP_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bit_input,
	input wire logic shift_clk,
	input wire logic store_clk,
	input wire logic shift_clear_n,
	input wire logic out_en_n,
	output logic [STAGES-1:0] par_out,
	output logic par_oe,
	output logic cascade_out,
	output logic event_room,
	output logic event_lost
);

	// ======================================================================
	// declarations
	typedef enum logic [1:0] {
		SSSR_ST_IDLE,
		SSSR_ST_GAP,
		SSSR_ST_CLEAR
	} sssr_state_t;

	localparam int GW = $clog2(DRAIN_GAP + 1);

	sssr_pins_t pins_raw;
	sssr_pins_t pins_sync;
	logic shift_lvl_reg;
	logic store_lvl_reg;
	logic shift_rise;
	logic store_rise;
	logic clear_act;
	sssr_evt_t evt_in;
	sssr_evt_t evt_out;
	logic evt_push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic drain_ready;
	logic evt_pop;
	sssr_state_t state_reg;
	sssr_state_t state_next;
	logic [GW-1:0] gap_reg;
	logic [STAGES-1:0] stages_reg;
	logic [STAGES-1:0] store_reg;
	logic par_oe_reg;
	logic room_reg;
	logic lost_reg;

	// ======================================================================
	// pin sampling
	assign pins_raw = '{
		bit_input: bit_input,
		shift_clk: shift_clk,
		store_clk: store_clk,
		shift_clear_n: shift_clear_n,
		out_en_n: out_en_n
	};

	// every pin is foreign to clk, so all pass two flops first
	sssr_sync #(
		.WIDTH($bits(sssr_pins_t)),
		.RST_VAL(SSSR_PINS_RST)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.din(pins_raw),
		.dout(pins_sync)
	);

	// ======================================================================
	// edge detection on the two link clocks
	// last sampled level of each clock, kept apart so the clocks stay independent
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_lvl_reg <= SSSR_LEVEL_LOW;
			store_lvl_reg <= SSSR_LEVEL_LOW;
		end else begin
			shift_lvl_reg <= pins_sync.shift_clk;
			store_lvl_reg <= pins_sync.store_clk;
		end
	end

	// R3 rising edges only
	assign shift_rise = pins_sync.shift_clk && !shift_lvl_reg;
	assign store_rise = pins_sync.store_clk && !store_lvl_reg;
	assign clear_act = !pins_sync.shift_clear_n;

	// ======================================================================
	// event queue
	// R6 tied clocks give one word with both flags set, applied together
	assign evt_in = '{
		do_shift: shift_rise,
		do_store: store_rise,
		bit_val: pins_sync.bit_input
	};

	// while clear is low nothing is queued: the stages are forced to zero
	assign evt_push = (shift_rise || store_rise) && !clear_act;

	// the queue absorbs bursts when the drain side is held off
	sssr_fifo #(
		.WIDTH($bits(sssr_evt_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.flush(clear_act),
		.in_valid(evt_push),
		.in_ready(fifo_in_ready),
		.in_data(evt_in),
		.out_valid(fifo_out_valid),
		.out_ready(drain_ready),
		.out_data(evt_out)
	);

	assign evt_pop = fifo_out_valid && drain_ready;

	// ======================================================================
	// drain pacing state machine
	// the gap state stalls the drain so the queue can really fill
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SSSR_ST_IDLE: begin
				if (clear_act) begin
					state_next = SSSR_ST_CLEAR;
				end else if (evt_pop && (DRAIN_GAP > 1)) begin
					state_next = SSSR_ST_GAP;
				end
			end
			SSSR_ST_GAP: begin
				if (clear_act) begin
					state_next = SSSR_ST_CLEAR;
				end else if (gap_reg == '0) begin
					state_next = SSSR_ST_IDLE;
				end
			end
			SSSR_ST_CLEAR: begin
				if (!clear_act) begin
					state_next = SSSR_ST_IDLE;
				end
			end
			default: begin
				state_next = SSSR_ST_IDLE;
			end
		endcase
	end

	assign drain_ready = (state_reg == SSSR_ST_IDLE) && !clear_act;

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= SSSR_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// gap counter: loaded on a pop, counts down in the gap state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_reg <= '0;
		end else if (evt_pop && (DRAIN_GAP > 1)) begin
			gap_reg <= GW'(DRAIN_GAP - 2);
		end else if ((state_reg == SSSR_ST_GAP) && (gap_reg != '0)) begin
			gap_reg <= gap_reg - GW'(1);
		end
	end

	// ======================================================================
	// shift register stages
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stages_reg <= SSSR_STAGES_RST;
		end else if (clear_act) begin
			// R4 clear overrides all shifting
			stages_reg <= SSSR_STAGES_CLR;
		end else if (evt_pop && evt_out.do_shift) begin
			// R1 move on one place, new bit enters the first stage
			stages_reg <= {stages_reg[STAGES-2:0], evt_out.bit_val};
		end
	end

	// ======================================================================
	// storage register
	// a store during clear copies the zeroed stages directly
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			store_reg <= SSSR_STAGES_RST;
		end else if (clear_act && store_rise) begin
			// R2 parallel copy of the cleared stages
			store_reg <= SSSR_STAGES_CLR;
		end else if (evt_pop && evt_out.do_store) begin
			// R6 copies the stages before this word's shift lands
			store_reg <= stages_reg;
		end
	end

	// ======================================================================
	// output enable
	// drive while the enable pin is low; flop keeps par_oe glitch free
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			par_oe_reg <= SSSR_LEVEL_LOW;
		end else begin
			// R8 enable high floats the outputs
			par_oe_reg <= !pins_sync.out_en_n;
		end
	end

	// ======================================================================
	// queue status
	// room is registered so the port comes from a flop; one cycle late
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			room_reg <= SSSR_LEVEL_HIGH;
		end else begin
			room_reg <= fifo_in_ready;
		end
	end

	// sticky loss flag: an event met a full queue; cleared by shift clear
	// set wins over clear only when both come together is impossible, since
	// no event is pushed while clear is low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lost_reg <= SSSR_LEVEL_LOW;
		end else if (evt_push && !fifo_in_ready) begin
			lost_reg <= SSSR_LEVEL_HIGH;
		end else if (clear_act) begin
			lost_reg <= SSSR_LEVEL_LOW;
		end
	end

	// ======================================================================
	// outputs
	// R7 parallel outputs only from the storage register
	assign par_out = store_reg;
	assign par_oe = par_oe_reg;
	// R5 last stage feeds the next device in a chain
	assign cascade_out = stages_reg[STAGES-1];
	assign event_room = room_reg;
	assign event_lost = lost_reg;

endmodule

/* File: bench/sssr_core_props.sv */
// checker for the pin-sampled shift and storage register
`timescale 1ns/100ps
module sssr_core_props
	import sssr_pkg::*;
#(
	parameter int STAGES = SSSR_STAGES,
	parameter int DEPTH = SSSR_FIFO_DEPTH,
	parameter int DRAIN_GAP = SSSR_DRAIN_GAP_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bit_input,
	input wire logic shift_clk,
	input wire logic store_clk,
	input wire logic shift_clear_n,
	input wire logic out_en_n,
	input wire logic [STAGES-1:0] par_out,
	input wire logic par_oe,
	input wire logic cascade_out,
	input wire logic event_room,
	input wire logic event_lost
);
	// ========
	// ages since the last shift rise, store rise and clear
	logic [9:0] sh_age_reg;
	logic [9:0] st_age_reg;
	logic [9:0] cl_age_reg;
	// saturating, so a queued event still counts as recent when it lands
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sh_age_reg <= 10'h3FF;
		end else if ($rose(shift_clk)) begin
			sh_age_reg <= 10'h000;
		end else if (sh_age_reg != 10'h3FF) begin
			sh_age_reg <= sh_age_reg + 10'h001;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_age_reg <= 10'h3FF;
		end else if ($rose(store_clk)) begin
			st_age_reg <= 10'h000;
		end else if (st_age_reg != 10'h3FF) begin
			st_age_reg <= st_age_reg + 10'h001;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cl_age_reg <= 10'h3FF;
		end else if (!shift_clear_n) begin
			cl_age_reg <= 10'h000;
		end else if (cl_age_reg != 10'h3FF) begin
			cl_age_reg <= cl_age_reg + 10'h001;
		end
	end
	// ========
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence clr_held;
		!shift_clear_n [*5];
	endsequence
	chk_oe_drive: assert property (!out_en_n [*6] |-> par_oe)
		else $error("outputs not driven while enabled");
	chk_oe_float: assert property (out_en_n [*6] |-> !par_oe)
		else $error("outputs driven while disabled");
	chk_clear_zero: assert property (clr_held |-> !cascade_out)
		else $error("cascade output set during clear");
	chk_lost_clear: assert property (clr_held |-> !event_lost)
		else $error("lost flag kept during clear");
	chk_lost_full: assert property ($rose(event_lost) |->
		!(event_room && $past(event_room) && $past(event_room, 2) && $past(event_room, 3)))
		else $error("event lost with room in queue");
	chk_par_quiet: assert property ($changed(par_out) |-> st_age_reg < 10'd400)
		else $error("parallel outputs moved without store");
	// cascade moves on shift or clear
	chk_casc_src: assert property ($changed(cascade_out) |->
		sh_age_reg < 10'd400 || cl_age_reg < 10'd8)
		else $error("cascade moved without shift or clear");
	chk_store_copy: assert property ($changed(par_out) && sh_age_reg > 10'd400 |->
		par_out[STAGES-1] == cascade_out)
		else $error("stored last stage differs from cascade");
endmodule
bind sssr_core sssr_core_props #(.STAGES(STAGES), .DEPTH(DEPTH), .DRAIN_GAP(DRAIN_GAP)) chk_u (
	.clk(clk), .rst_b(rst_b), .bit_input(bit_input), .shift_clk(shift_clk),
	.store_clk(store_clk), .shift_clear_n(shift_clear_n), .out_en_n(out_en_n),
	.par_out(par_out), .par_oe(par_oe), .cascade_out(cascade_out),
	.event_room(event_room), .event_lost(event_lost));

/* File: bench/sssr_host.sv */
// host controller model driving the serial pins
`timescale 1ns/100ps
module sssr_host (
	input wire logic clk,
	output logic bit_input,
	output logic shift_clk,
	output logic store_clk,
	output logic shift_clear_n,
	output logic out_en_n
);
	localparam int HALF = 16; // 16 high and 15 low: 124 ns, close to the 125 ns link period
	// idle pins: clocks low, clear off, outputs disabled
	initial begin
		bit_input = 1'h0;
		shift_clk = 1'h0;
		store_clk = 1'h0;
		shift_clear_n = 1'h1;
		out_en_n = 1'h1;
	end
	task automatic pulse(input logic b, input logic sh, input logic st, input logic skew);
		@(posedge clk);
		bit_input <= b;
		repeat (HALF - 2) @(posedge clk);
		shift_clk <= sh;
		if (skew) begin
			repeat (HALF / 2) @(posedge clk);
		end
		store_clk <= st;
		@(posedge clk);
		bit_input <= ~b; // one clk of hold time: the line stops showing the bit a cycle after the rise
		repeat (HALF - 1) @(posedge clk);
		shift_clk <= 1'h0;
		store_clk <= 1'h0;
	endtask
	// clear held 8 cycles; a store may rise in the middle of it
	task automatic clear_pulse(input logic st);
		@(posedge clk);
		shift_clear_n <= 1'h0;
		repeat (4) @(posedge clk);
		store_clk <= st;
		repeat (4) @(posedge clk);
		shift_clear_n <= 1'h1;
		store_clk <= 1'h0;
	endtask
	task automatic set_oe(input logic v);
		@(posedge clk);
		out_en_n <= v;
	endtask
endmodule

/* File: bench/test_sssr_core.sv */
// self-checking bench for the shift and storage register
`timescale 1ns/100ps
module test_sssr_core;
	logic clk, rst_b, bit_input, shift_clk, store_clk, shift_clear_n, out_en_n;
	logic [7:0] par_out;
	logic par_oe, cascade_out, event_room, event_lost;
	wire logic [7:0] par_pin;
	int miscompares;
	int checked;
	logic [7:0] exp_sr;
	logic [7:0] exp_par;
	logic room_low_reg;
	// queue full may come and go inside a pulse, so watch every cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			room_low_reg <= 1'h0;
		end else if (event_room === 1'h0) begin
			room_low_reg <= 1'h1;
		end
	end
	// pin level: floats unless the block drives it
	assign par_pin = par_oe ? par_out : 8'hZZ;
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// slow drain so the queue can be filled at the link rate
	sssr_core #(.DRAIN_GAP(40)) dut_u (.clk(clk), .rst_b(rst_b), .bit_input(bit_input),
		.shift_clk(shift_clk), .store_clk(store_clk), .shift_clear_n(shift_clear_n),
		.out_en_n(out_en_n), .par_out(par_out), .par_oe(par_oe), .cascade_out(cascade_out),
		.event_room(event_room), .event_lost(event_lost));
	sssr_host host_u (.clk(clk), .bit_input(bit_input), .shift_clk(shift_clk),
		.store_clk(store_clk), .shift_clear_n(shift_clear_n), .out_en_n(out_en_n));
	// ========
	// shared tasks
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wait_par(input logic [7:0] exp);
		int n;
		for (n = 0; n < 800 && par_pin !== exp; n++) @(posedge clk);
		cmp8(par_pin, exp);
		if (n == 800) final_report();
	endtask
	// first bit in ends up in the last stage
	task automatic send(input logic [7:0] v, input logic tied);
		for (int i = 7; i >= 0; i--) begin
			if (tied) exp_par = exp_sr;
			host_u.pulse(v[i], 1'h1, tied, 1'h0);
			exp_sr = {exp_sr[6:0], v[i]};
		end
	endtask
	task automatic store();
		host_u.pulse(1'h0, 1'h0, 1'h1, 1'h0);
		exp_par = exp_sr;
	endtask
	// ========
	// scenarios
	task automatic t_basic();
		send(8'hA5, 1'h0);
		repeat (420) @(posedge clk); // every shift lands before the store
		store();
		wait_par(exp_par);
		cmp8({7'h00, cascade_out}, {7'h00, exp_sr[7]});
		send(8'h3C, 1'h0);
		repeat (400) @(posedge clk);
		cmp8(par_pin, exp_par);
		cmp8({7'h00, cascade_out}, {7'h00, exp_sr[7]});
	endtask
	task automatic t_tied();
		send(8'h96, 1'h1);
		wait_par(exp_par);
	endtask
	task automatic t_oe();
		host_u.set_oe(1'h1);
		repeat (8) @(posedge clk);
		cmp8(par_pin, 8'hZZ);
		host_u.set_oe(1'h0);
		repeat (8) @(posedge clk);
		cmp8(par_pin, exp_par);
	endtask
	task automatic t_clear();
		// a store inside the clear copies the zeroed stages
		host_u.clear_pulse(1'h1);
		repeat (8) @(posedge clk);
		cmp8({7'h00, cascade_out}, 8'h00);
		cmp8(par_pin, 8'h00);
		host_u.pulse(1'h1, 1'h1, 1'h0, 1'h0);
		exp_sr = 8'h01;
		store();
		wait_par(exp_par);
	endtask
	// skewed edges give two events per period, more than the drain takes
	task automatic t_flood();
		int n;
		for (n = 0; n < 60 && event_lost !== 1'h1; n++) begin
			host_u.pulse(n[0], 1'h1, 1'h1, 1'h1);
		end
		cmp8({7'h00, event_lost}, 8'h01);
		cmp8({7'h00, room_low_reg}, 8'h01);
		repeat (400) @(posedge clk);
		cmp8({7'h00, event_room}, 8'h01);
		host_u.clear_pulse(1'h0);
		repeat (8) @(posedge clk);
		cmp8({7'h00, event_lost}, 8'h00);
		cmp8({7'h00, cascade_out}, 8'h00);
		if (n == 60) final_report();
	endtask
	initial begin
		miscompares = 0;
		checked = 0;
		exp_sr = 8'h00;
		exp_par = 8'h00;
		rst_b = 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		host_u.set_oe(1'h0);
		t_basic();
		t_tied();
		t_oe();
		t_clear();
		t_flood();
		final_report();
	end
endmodule
